// ---- rtl/dps_top.sv ----
`timescale 1ns/10ps
`include "dps_regs.svh"
module dps_top
  import dps_pkg::*;
#(
  parameter int BUF_DIS_CYC = `DPS_BUF_DIS_CYC,
  parameter int BUSY_CYC = `DPS_BUSY_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cke_in,
  input wire dps_cmd_s cmd_in,
  input wire logic temp_hot_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output logic buffers_en_out,
  output logic dll_on_out,
  output logic powerdown_out,
  output logic fast_refresh_out
);
  localparam logic [3:0] BUF_DIS = 4'(BUF_DIS_CYC);
  localparam logic [3:0] BUSY = 4'(BUSY_CYC);

  // CKE, command and sensor pins are asynchronous to the core; two stages each
  logic cke_s1, cke_s2, hot_s1, hot_s2;
  dps_cmd_s cmd_s1, cmd_s2;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      // Idle high, so a release with NOP never fakes an entry
      cke_s1 <= 1'b1;
      cke_s2 <= 1'b1;
      hot_s1 <= 1'b0;
      hot_s2 <= 1'b0;
      cmd_s1 <= '{op: op_des, bank: 3'h0};
      cmd_s2 <= '{op: op_des, bank: 3'h0};
    end else begin
      cke_s1 <= cke_in;
      cke_s2 <= cke_s1;
      hot_s1 <= temp_hot_in;
      hot_s2 <= hot_s1;
      cmd_s1 <= cmd_in;
      cmd_s2 <= cmd_s1;
    end
  end

  logic is_nop;
  assign is_nop = (cmd_s2.op == op_nop) || (cmd_s2.op == op_des);

  // Register file
  logic [15:0] sr_cfg, pd_cfg, next_sr_cfg, next_pd_cfg, next_rdata;
  dps_status_s status;
  logic auto_self_refresh, extended_temp_self_refresh, fast_exit;
  assign auto_self_refresh = sr_cfg[`DPS_ASR_BIT];
  assign extended_temp_self_refresh = sr_cfg[`DPS_SRT_BIT];
  assign fast_exit = pd_cfg[`DPS_FAST_EXIT_BIT];

  always_comb begin
    next_sr_cfg = sr_cfg;
    next_pd_cfg = pd_cfg;
    next_rdata = 16'h0000;
    if (reg_wr_in && reg_addr_in == `DPS_ADDR_SR_CFG) begin
      next_sr_cfg = reg_wdata_in;
    end
    if (reg_wr_in && reg_addr_in == `DPS_ADDR_PD_CFG) begin
      next_pd_cfg = reg_wdata_in;
    end
    // Temperature config is write-only and reads as zero
    if (reg_rd_in && reg_addr_in == `DPS_ADDR_PD_CFG) begin
      next_rdata = pd_cfg;
    end
    if (reg_rd_in && reg_addr_in == `DPS_ADDR_STATUS) begin
      next_rdata = {1'b0, status};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sr_cfg <= `DPS_CFG_RESET;
      pd_cfg <= `DPS_CFG_RESET;
      reg_rdata_out <= 16'h0000;
    end else begin
      sr_cfg <= next_sr_cfg;
      pd_cfg <= next_pd_cfg;
      reg_rdata_out <= next_rdata;
    end
  end

  // Per-bank open state
  logic [7:0] banks, next_banks;
  dps_state_e state, next_state;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bank
      always_comb begin
        next_banks[gi] = banks[gi];
        if (state == st_up && cmd_s2.bank == 3'(gi) && cmd_s2.op == op_act) begin
          next_banks[gi] = 1'b1;
        end
        if (state == st_up && ((cmd_s2.bank == 3'(gi) && cmd_s2.op == op_pre) || cmd_s2.op == op_prea)) begin
          next_banks[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // Power-down sequencing
  logic [3:0] busy, next_busy, ent_cnt, next_ent_cnt;
  logic next_buffers, next_dll, next_pd, next_fast_ref;

  always_comb begin
    next_state = state;
    next_busy = (busy != 4'h0) ? busy - 4'h1 : 4'h0;
    next_ent_cnt = (ent_cnt != 4'h0) ? ent_cnt - 4'h1 : 4'h0;
    case (state)
      st_up: begin
        if (cmd_s2.op == op_rd || cmd_s2.op == op_wr || cmd_s2.op == op_mrs) begin
          next_busy = BUSY;
        end
        if (!cke_s2 && is_nop) begin
          next_state = st_entry;
          next_ent_cnt = BUF_DIS;
        end
      end
      st_entry: begin
        // Kind is chosen only once pending bursts have drained
        if (cke_s2 && is_nop) begin
          next_state = st_up;
        end else if (ent_cnt == 4'h0 && busy == 4'h0) begin
          next_state = (banks != 8'h00) ? st_active_pd : st_prech_pd;
        end
      end
      st_active_pd, st_prech_pd: begin
        if (cke_s2 && is_nop) begin
          next_state = st_up;
        end
      end
      default: next_state = st_up;
    endcase
    next_pd = (next_state == st_active_pd) || (next_state == st_prech_pd);
    next_buffers = !next_pd;
    next_dll = !(next_state == st_prech_pd && !fast_exit);
    // Auto mode follows the sensor; otherwise software's range choice
    next_fast_ref = auto_self_refresh ? hot_s2 : extended_temp_self_refresh;
  end

  // Synchronous reset also pulls the block out of power-down
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= st_up;
      banks <= 8'h00;
      busy <= 4'h0;
      ent_cnt <= 4'h0;
      powerdown_out <= 1'b0;
      buffers_en_out <= 1'b1;
      dll_on_out <= 1'b1;
      fast_refresh_out <= 1'b0;
    end else begin
      state <= next_state;
      banks <= next_banks;
      busy <= next_busy;
      ent_cnt <= next_ent_cnt;
      powerdown_out <= next_pd;
      buffers_en_out <= next_buffers;
      dll_on_out <= next_dll;
      fast_refresh_out <= next_fast_ref;
    end
  end

  always_comb begin
    status = '0;
    status.illegal_combo = auto_self_refresh && extended_temp_self_refresh;
    status.hot = hot_s2;
    status.fast_refresh = fast_refresh_out;
    status.dll_on = dll_on_out;
    status.buffers_on = buffers_en_out;
    status.prech_pd = (state == st_prech_pd);
    status.active_pd = (state == st_active_pd);
    status.banks_open = banks;
  end

  pd_entry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_up && !cke_s2 && is_nop |=> state == st_entry)
    else $error("power-down entry missed");

  buf_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    powerdown_out |-> !buffers_en_out && (state == st_active_pd || state == st_prech_pd))
    else $error("buffers on in power-down");

  pd_kind_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_entry && ent_cnt == 4'h0 && busy == 4'h0 && !(cke_s2 && is_nop)
    |=> state == (($past(banks) != 8'h00) ? st_active_pd : st_prech_pd))
    else $error("wrong power-down kind");

  slow_exit_dll_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_prech_pd |-> dll_on_out == $past(fast_exit))
    else $error("dll state wrong in precharge power-down");

  auto_rate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    auto_self_refresh |=> fast_refresh_out == $past(hot_s2))
    else $error("auto rate does not follow temperature");

  reset_exit_a: assert property (@(posedge clk_in)
    !rst_n_in |=> state == st_up && !powerdown_out && dll_on_out)
    else $error("reset did not leave power-down");

  pd_exit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    powerdown_out && cke_s2 && is_nop |=> state == st_up && !powerdown_out && buffers_en_out && dll_on_out)
    else $error("power-down exit missed");

  entry_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_entry && (ent_cnt != 4'h0 || busy != 4'h0) && !(cke_s2 && is_nop) |=> state == st_entry)
    else $error("power-down chosen before pending work drained");

  entry_abort_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_entry && cke_s2 && is_nop |=> state == st_up && !powerdown_out)
    else $error("aborted entry did not return to up");

  entry_outputs_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_entry |-> buffers_en_out && dll_on_out && !powerdown_out)
    else $error("outputs changed before power-down reached");

  entry_count_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_up && !cke_s2 && is_nop |=> ent_cnt == BUF_DIS)
    else $error("buffer-disable count not loaded");

  up_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_up && !(!cke_s2 && is_nop) |=> state == st_up)
    else $error("left up state without entry command");

  pd_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    powerdown_out && !(cke_s2 && is_nop) |=> powerdown_out)
    else $error("power-down left without exit command");

  up_outputs_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !powerdown_out |-> buffers_en_out && dll_on_out)
    else $error("buffers or dll off outside power-down");

  active_dll_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_active_pd |-> dll_on_out && !buffers_en_out)
    else $error("dll off in active power-down");

  // Bank bits only move in the up state, so the kind stays fixed
  active_kind_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_active_pd |-> banks != 8'h00)
    else $error("active power-down with all banks closed");

  prech_kind_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_prech_pd |-> banks == 8'h00)
    else $error("precharge power-down with a bank open");

  bank_open_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_up && cmd_s2.op == op_act |=> banks[$past(cmd_s2.bank)])
    else $error("activate did not open bank");

  pre_close_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_up && cmd_s2.op == op_pre |=> !banks[$past(cmd_s2.bank)])
    else $error("precharge did not close bank");

  bank_all_close_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_up && cmd_s2.op == op_prea |=> banks == 8'h00)
    else $error("precharge all left a bank open");

  busy_load_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_up && (cmd_s2.op == op_rd || cmd_s2.op == op_wr || cmd_s2.op == op_mrs) |=> busy == BUSY)
    else $error("pending burst not recorded");

  manual_rate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !auto_self_refresh |=> fast_refresh_out == $past(extended_temp_self_refresh))
    else $error("manual rate does not follow range bit");

  active_pd_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_entry ##1 state == st_active_pd);
  slow_pd_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_prech_pd && !dll_on_out ##[1:20] state == st_up);
  auto_hot_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    auto_self_refresh && fast_refresh_out);
  fast_exit_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    state == st_prech_pd && dll_on_out ##1 state == st_up);
  reset_pd_c: cover property (@(posedge clk_in)
    powerdown_out && !rst_n_in);
endmodule

// ---- rtl/dps_regs.svh ----
`ifndef DPS_REGS_SVH
`define DPS_REGS_SVH
`define DPS_ADDR_SR_CFG 4'h0
`define DPS_ADDR_PD_CFG 4'h4
`define DPS_ADDR_STATUS 4'h8
`define DPS_ASR_BIT 6
`define DPS_SRT_BIT 7
`define DPS_FAST_EXIT_BIT 12
`define DPS_CFG_RESET 16'h0000
`define DPS_CLK_MHZ 40
`define DPS_BUF_DIS_NS 25
`define DPS_BUF_DIS_CYC ((`DPS_BUF_DIS_NS * `DPS_CLK_MHZ + 999) / 1000)
`define DPS_BUSY_CYC 4
`endif

// ---- rtl/dps_pkg.sv ----
package dps_pkg;
  typedef enum logic [3:0] {
    op_nop, op_des, op_act, op_pre, op_prea, op_rd, op_wr, op_ref, op_mrs
  } dps_op_e;
  typedef struct packed {
    dps_op_e op;
    logic [2:0] bank;
  } dps_cmd_s;
  typedef enum logic [1:0] {st_up, st_entry, st_active_pd, st_prech_pd} dps_state_e;
  typedef struct packed {
    logic illegal_combo;
    logic hot;
    logic fast_refresh;
    logic dll_on;
    logic buffers_on;
    logic prech_pd;
    logic active_pd;
    logic [7:0] banks_open;
  } dps_status_s;
endpackage

// ---- tb/dps_host.sv ----
`timescale 1ns/10ps
module dps_host
  import dps_pkg::*;
(
  input wire logic clk_in,
  output logic cke_out,
  output dps_cmd_s cmd_out
);
  initial begin
    cke_out = 1'b1;
    cmd_out = '{op_nop, 3'h0};
  end
  // Idle tail lets bursts and recovery drain before CKE may fall
  task automatic send(input dps_op_e op, input logic [2:0] bank);
    @(posedge clk_in);
    cmd_out <= '{op, bank};
    @(posedge clk_in);
    cmd_out <= '{op_des, ~bank};
    repeat (10) @(posedge clk_in);
  endtask
  task automatic pd_enter();
    @(posedge clk_in);
    cke_out <= 1'b0;
    cmd_out <= '{op_nop, 3'h5};
    repeat (12) @(posedge clk_in);
  endtask
  // Same 12-cycle wait for every exit, plus an MRS and its idle tail after a slow exit, so no latency is ever cut short
  task automatic pd_exit(input logic slow);
    @(posedge clk_in);
    cke_out <= 1'b1;
    cmd_out <= '{op_des, 3'h2};
    repeat (12) @(posedge clk_in);
    if (slow) send(op_mrs, 3'h0);
  endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
  import dps_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cke;
  logic hot = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [7:0] banks = 8'h00;
  logic buf_en, dll, pd, fr;
  dps_cmd_s cmd;
  int n_fail = 0;
  int compares = 0;
  always #12.5 clk_in = ~clk_in;
  dps_host host_u (.clk_in(clk_in), .cke_out(cke), .cmd_out(cmd));
  dps_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .cke_in(cke), .cmd_in(cmd), .temp_hot_in(hot),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .buffers_en_out(buf_en), .dll_on_out(dll), .powerdown_out(pd), .fast_refresh_out(fr));
  task automatic conclude();
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic cmp_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %b got %b", name, exp, got);
    end
  endtask
  // Auto option follows the sensor, otherwise the range bit
  function automatic logic rate(input logic auto_on, input logic ext_on);
    return auto_on ? hot : ext_on;
  endfunction
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 cmp("rdata", exp, rdata);
  endtask
  function automatic logic [15:0] st(input logic apd, ppd, b, d, f, h, il);
    return {1'b0, il, h, f, d, b, ppd, apd, banks};
  endfunction
  // Bounded poll, a stuck state shows up as a mismatch
  task automatic wait_pd(input logic v);
    for (int i = 0; i < 12 && pd !== v; i++) begin
      @(posedge clk_in);
      #1;
    end
    cmp_bit("powerdown", v, pd);
  endtask
  initial begin
    #(25 * 8000);
    n_fail++;
    conclude();
  end
  initial begin
    logic a, e, f, o;
    logic [2:0] b;
    void'($urandom(32'ha849));
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd_reg(4'h8, st(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
    rd_reg(4'h0, 16'h0000);
    rd_reg(4'hC, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      a = i[0];
      e = i[1];
      @(posedge clk_in);
      hot <= 1'($urandom);
      wr_reg(4'h0, {8'h00, e, a, 6'h00});
      repeat (4) @(posedge clk_in);
      #1 cmp_bit("fast_refresh", rate(a, e), fr);
      rd_reg(4'h8, st(1'b0, 1'b0, 1'b1, 1'b1, rate(a, e), hot, a & e));
    end
    wr_reg(4'h0, 16'h0080);
    for (int i = 0; i < 4; i++) begin
      o = i[0];
      f = i[1];
      b = 3'($urandom);
      wr_reg(4'h4, {3'h0, f, 12'h000});
      rd_reg(4'h4, {3'h0, f, 12'h000});
      if (o) host_u.send(op_act, b);
      if (o) host_u.send(op_wr, b);
      banks[b] = o;
      host_u.pd_enter();
      wait_pd(1'b1);
      cmp_bit("buffers", 1'b0, buf_en);
      cmp_bit("dll", o | f, dll);
      rd_reg(4'h8, st(o, !o, 1'b0, o | f, 1'b1, hot, 1'b0));
      host_u.pd_exit(!o && !f);
      wait_pd(1'b0);
      cmp_bit("buffers", 1'b1, buf_en);
      cmp_bit("dll", 1'b1, dll);
      if (o) host_u.send(op_pre, b);
      banks[b] = 1'b0;
      host_u.send(op_ref, 3'h0);
    end
    b = 3'($urandom);
    host_u.send(op_act, b);
    host_u.send(op_act, b + 3'h1);
    host_u.send(op_rd, b);
    banks[b] = 1'b1;
    banks[b + 3'h1] = 1'b1;
    rd_reg(4'h8, st(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, hot, 1'b0));
    host_u.send(op_prea, 3'h0);
    banks = 8'h00;
    rd_reg(4'h8, st(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, hot, 1'b0));
    host_u.pd_enter();
    wait_pd(1'b1);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1 cmp_bit("powerdown", 1'b0, pd);
    cmp_bit("buffers", 1'b1, buf_en);
    host_u.pd_exit(1'b0);
    rst_n_in <= 1'b1;
    rd_reg(4'h4, 16'h0000);
    rd_reg(4'h8, st(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, hot, 1'b0));
    conclude();
  end
endmodule
